// *** hdl/ssp_pkg.sv ***
// What this block does
// - parallel port is 16 bits single data rate, same rate both directions
// - transceiver outputs the parallel clock; receive data changes on its falling edge, transmit data is taken on tx_clk
// - two receive symbols per cycle, first one in bits 7-0
// - receive k-flag bit per byte: zero data, one control
// - receive valid high only with symbol lock and valid data
// - low phy reset input, synced through two flops, resets transmit and receive logic
// - transmit idle force puts transmitter in electrical idle, per power state
// - 3-bit receive status codes: ok, skip add/remove, detect, errors
// - underflow code never reported in nominally-empty elastic buffer mode
// - 2-bit power state: P0 normal, P1, P2, P3 lowest power
// - P3 to P0 handshake is asynchronous, not tied to the parallel clock
// - completion output marks power changes and receiver detection
// - completion toggling around P3 with clock stopped is sampled asynchronously
// - power-present output follows bus supply detection
// - ones-zeros input sends alternating 50-250 bit runs, ignoring transmit data
// - de-emphasis select coding; new setting applied within 128 ns
// - margin 000 gives normal full and half swing voltage ranges
// - elastic buffer mode 0 half-full, 1 nominally empty
package ssp_pkg;
  localparam int CLK_NS = 10;
  localparam int DEEMPH_NS = 128;
  // two sync flops and the capture cycle come out of the de-emphasis budget
  localparam int SYNC_CYC = 3;
  localparam int DEEMPH_CYC = DEEMPH_NS / CLK_NS - SYNC_CYC;
  localparam int PS_CHANGE_NS = 200;
  localparam int PS_CHANGE_CYC = (PS_CHANGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DETECT_NS = 400;
  localparam int DETECT_CYC = (DETECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PCLK_HALF = 4;
  localparam int DONE_CYC = 2 * PCLK_HALF;
  localparam int RUN_LEN = 100;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INJECT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_TXCAP = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_LOCK = 0;
  localparam int CTRL_FAR = 1;
  localparam int CTRL_LFPS = 2;
  localparam int CTRL_VBUS = 3;
  localparam int INJ_K = 16;
  localparam int INJ_ST = 18;
  localparam logic [2:0] RXS_OK = 3'h0;
  localparam logic [2:0] RXS_DETECTED = 3'h3;
  localparam logic [2:0] RXS_UNDERFLOW = 3'h6;
  localparam logic [1:0] PS_P0 = 2'h0;
  localparam logic [1:0] PS_P1 = 2'h1;
  localparam logic [1:0] PS_P2 = 2'h2;
  localparam logic [1:0] PS_P3 = 2'h3;
  localparam logic [1:0] DEEMPH_RESET = 2'h2;
  localparam logic [2:0] MARGIN_NORMAL = 3'h0;
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_CHANGE = 2'b01,
    SSP_DETECT = 2'b10,
    SSP_DONE = 2'b11
  } ssp_state_t;
endpackage : ssp_pkg

// *** hdl/ssp_port.sv ***
module ssp_port
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_n_a,
  input wire logic tx_clk,
  input wire logic [15:0] tx_data,
  input wire logic [1:0] tx_k_flags,
  input wire logic detect_or_loopback_req,
  input wire logic tx_idle_force,
  input wire logic [1:0] power_state,
  input wire logic compliance_toggle_pattern,
  input wire logic [1:0] deemphasis_select,
  input wire logic [2:0] tx_voltage_margin,
  input wire logic elastic_buffer_mode_sel,
  input wire logic config_mode_hi,
  input wire logic config_mode_lo,
  output logic pclk,
  output logic [15:0] rx_data,
  output logic [1:0] rx_k_flags,
  output logic rx_valid,
  output logic [2:0] rx_status,
  output logic rx_idle_indicator,
  output logic completion_strobe,
  output logic bus_power_present,
  output logic tx_line_idle,
  output logic tx_line_level
);
  import ssp_pkg::*;

  // every phy pin passes two flops; the first stage is read only by the second
  localparam int SYW = 33;
  logic [SYW-1:0] pin_s1_reg;
  logic [SYW-1:0] pin_s2_reg;
  logic [SYW-1:0] pins;
  logic clk_s3_reg;
  assign pins = {reset_n_a, tx_clk, tx_data, tx_k_flags, detect_or_loopback_req,
                 tx_idle_force, power_state, compliance_toggle_pattern, deemphasis_select,
                 tx_voltage_margin, elastic_buffer_mode_sel, config_mode_hi, config_mode_lo};
  always_ff @(posedge aclk)
  begin
    pin_s1_reg <= pins;
    pin_s2_reg <= pin_s1_reg;
    clk_s3_reg <= pin_s2_reg[31];
  end

  logic rst_n_s;
  logic txclk_s;
  logic [15:0] txd_s;
  logic [1:0] txk_s;
  logic req_s;
  logic idle_s;
  logic [1:0] ps_s;
  logic ones_s;
  logic [1:0] deemph_s;
  logic [2:0] margin_s;
  logic ebuf_s;
  logic mode_hi_s;
  logic mode_lo_s;
  assign {rst_n_s, txclk_s, txd_s, txk_s, req_s, idle_s, ps_s, ones_s, deemph_s,
          margin_s, ebuf_s, mode_hi_s, mode_lo_s} = pin_s2_reg;

  // phy logic is held while either reset is low; the pin is asynchronous to aclk
  logic phy_rst;
  assign phy_rst = !aresetn || !rst_n_s;

  // mode pins follow continuously; a wrong strap just blanks the receive side
  logic mode_ok;
  assign mode_ok = !mode_hi_s && mode_lo_s;

  // ---------------- register bus ----------------
  logic [3:0] ctrl_reg;
  logic [20:0] inject_reg;
  logic inject_pend_reg;
  logic inject_take;
  logic [17:0] txcap_reg;
  logic [31:0] status_word;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
      inject_reg <= '0;
      inject_pend_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // a new word written in the cycle the old one is taken stays pending
      if (inject_take)
        inject_pend_reg <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        if (awaddr_reg == ADDR_CTRL)
        begin
          if (wstrb_reg[0])
            ctrl_reg <= wdata_reg[3:0];
        end
        else if (awaddr_reg == ADDR_INJECT)
        begin
          if (wstrb_reg[0])
            inject_reg[7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1])
            inject_reg[15:8] <= wdata_reg[15:8];
          if (wstrb_reg[2])
            inject_reg[20:16] <= wdata_reg[20:16];
          inject_pend_reg <= 1'b1;
        end
        else if (awaddr_reg == ADDR_STATUS || awaddr_reg == ADDR_TXCAP)
          s_axi_bresp <= RESP_OKAY;
        else
          s_axi_bresp <= RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr == ADDR_CTRL)
          s_axi_rdata <= {28'h0000000, ctrl_reg};
        else if (s_axi_araddr == ADDR_INJECT)
          s_axi_rdata <= {11'h000, inject_reg};
        else if (s_axi_araddr == ADDR_STATUS)
          s_axi_rdata <= status_word;
        else if (s_axi_araddr == ADDR_TXCAP)
          s_axi_rdata <= {14'h0000, txcap_reg};
        else
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
    end
  end

  // ---------------- parallel clock and beats ----------------
  logic [7:0] div_reg;
  logic beat_fall;
  assign beat_fall = pclk && (div_reg == PCLK_HALF[7:0] - CNT_ONE);

  // the clock stops in P3, so anything there runs on aclk alone
  always_ff @(posedge aclk)
  begin
    if (phy_rst)
    begin
      div_reg <= '0;
      pclk <= 1'b0;
    end
    else if (ps_s == PS_P3)
    begin
      div_reg <= '0;
      pclk <= 1'b0;
    end
    else if (div_reg == PCLK_HALF[7:0] - CNT_ONE)
    begin
      div_reg <= '0;
      pclk <= !pclk;
    end
    else
      div_reg <= div_reg + CNT_ONE;
  end

  // transmit words are taken mid-period, at the synced falling edge of tx_clk
  always_ff @(posedge aclk)
  begin
    if (phy_rst)
      txcap_reg <= '0;
    else if (!txclk_s && clk_s3_reg)
      txcap_reg <= {txk_s, txd_s};
  end

  // ---------------- power, detection, completion ----------------
  ssp_state_t state_reg;
  logic [7:0] cnt_reg;
  logic [1:0] ps_seen_reg;
  logic loop_reg;
  logic found_reg;

  always_ff @(posedge aclk)
  begin
    if (phy_rst)
    begin
      state_reg <= SSP_IDLE;
      cnt_reg <= '0;
      ps_seen_reg <= PS_P0;
      loop_reg <= 1'b0;
      found_reg <= 1'b0;
      completion_strobe <= 1'b0;
    end
    else
    begin
      if (ps_s != PS_P0 || !req_s)
        loop_reg <= 1'b0;
      case (state_reg)
        SSP_IDLE:
        begin
          completion_strobe <= 1'b0;
          if (ps_s != ps_seen_reg)
          begin
            ps_seen_reg <= ps_s;
            cnt_reg <= PS_CHANGE_CYC[7:0];
            state_reg <= SSP_CHANGE;
          end
          else if (req_s && ps_s == PS_P0)
            loop_reg <= 1'b1;
          else if (req_s && ps_s != PS_P0)
          begin
            cnt_reg <= DETECT_CYC[7:0];
            state_reg <= SSP_DETECT;
          end
        end
        SSP_CHANGE, SSP_DETECT:
        begin
          if (cnt_reg == CNT_ONE)
          begin
            found_reg <= (state_reg == SSP_DETECT) && ctrl_reg[CTRL_FAR];
            completion_strobe <= 1'b1;
            cnt_reg <= DONE_CYC[7:0];
            state_reg <= SSP_DONE;
          end
          else
            cnt_reg <= cnt_reg - CNT_ONE;
        end
        SSP_DONE:
        begin
          // held one pclk period so it is seen even with the clock stopped
          if (cnt_reg == CNT_ONE && !(req_s && ps_s != PS_P0))
          begin
            completion_strobe <= 1'b0;
            found_reg <= 1'b0;
            state_reg <= SSP_IDLE;
          end
          else if (cnt_reg != CNT_ONE)
            cnt_reg <= cnt_reg - CNT_ONE;
        end
        default:
          state_reg <= SSP_IDLE;
      endcase
    end
  end

  // ---------------- receive side ----------------
  logic [2:0] inj_status;
  always_comb
  begin
    inj_status = inject_reg[INJ_ST +: 3];
    if (ebuf_s && inj_status == RXS_UNDERFLOW)
      inj_status = RXS_OK;
  end

  logic locked;
  assign locked = ctrl_reg[CTRL_LOCK] && mode_ok && ps_s == PS_P0;
  assign inject_take = beat_fall && locked && inject_pend_reg && !loop_reg;

  // new words are loaded at the falling edge so they are steady at the rising edge
  always_ff @(posedge aclk)
  begin
    if (phy_rst)
    begin
      rx_data <= '0;
      rx_k_flags <= '0;
      rx_valid <= 1'b0;
      rx_status <= RXS_OK;
    end
    else if (state_reg == SSP_DONE && found_reg)
      rx_status <= RXS_DETECTED;
    else if (!locked)
    begin
      rx_valid <= 1'b0;
      rx_status <= RXS_OK;
    end
    else if (beat_fall)
    begin
      rx_valid <= loop_reg || inject_pend_reg;
      if (loop_reg)
      begin
        rx_data <= txcap_reg[15:0];
        rx_k_flags <= txcap_reg[17:16];
        rx_status <= RXS_OK;
      end
      else if (inject_pend_reg)
      begin
        rx_data <= inject_reg[15:0];
        rx_k_flags <= inject_reg[INJ_K +: 2];
        rx_status <= inj_status;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (phy_rst)
    begin
      rx_idle_indicator <= 1'b1;
      bus_power_present <= 1'b0;
    end
    else
    begin
      rx_idle_indicator <= !ctrl_reg[CTRL_LFPS];
      bus_power_present <= ctrl_reg[CTRL_VBUS];
    end
  end

  // ---------------- transmit line ----------------
  logic [1:0] deemph_reg;
  logic [1:0] deemph_want_reg;
  logic [7:0] deemph_cnt_reg;
  logic [2:0] margin_reg;
  logic [7:0] run_reg;

  always_ff @(posedge aclk)
  begin
    if (phy_rst)
    begin
      deemph_reg <= DEEMPH_RESET;
      deemph_want_reg <= DEEMPH_RESET;
      deemph_cnt_reg <= '0;
      margin_reg <= MARGIN_NORMAL;
    end
    else
    begin
      margin_reg <= margin_s;
      // the count restarts on each change, so the last setting always lands
      if (deemph_s != deemph_want_reg)
      begin
        deemph_want_reg <= deemph_s;
        deemph_cnt_reg <= DEEMPH_CYC[7:0];
      end
      else if (deemph_cnt_reg == CNT_ONE)
      begin
        deemph_reg <= deemph_want_reg;
        deemph_cnt_reg <= '0;
      end
      else if (deemph_cnt_reg != '0)
        deemph_cnt_reg <= deemph_cnt_reg - CNT_ONE;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (phy_rst)
    begin
      run_reg <= '0;
      tx_line_level <= 1'b0;
      tx_line_idle <= 1'b1;
    end
    else
    begin
      tx_line_idle <= idle_s || ps_s != PS_P0;
      if (!ones_s || idle_s)
      begin
        run_reg <= '0;
        tx_line_level <= txcap_reg[0];
      end
      else if (run_reg == RUN_LEN[7:0] - CNT_ONE)
      begin
        run_reg <= '0;
        tx_line_level <= !tx_line_level;
      end
      else
        run_reg <= run_reg + CNT_ONE;
    end
  end

  assign status_word = {21'h000000, mode_ok, state_reg != SSP_IDLE, loop_reg, rx_valid,
                        margin_reg, deemph_reg, ps_seen_reg};
endmodule : ssp_port

// *** testbench/ssp_mac_model.sv ***
module ssp_mac_model
(
  output logic tx_clk,
  output logic [15:0] tx_data,
  output logic [1:0] tx_k_flags,
  input wire logic [15:0] word_in,
  input wire logic [1:0] k_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running link clock, phase offset so it never lines up with aclk
  initial
  begin
    tx_clk = 1'b0;
    #3;
    forever #40 tx_clk = ~tx_clk;
  end
  // launched on the rising edge so the word is steady around the falling edge
  always @(posedge tx_clk)
  begin
    tx_data <= word_in;
    tx_k_flags <= k_in;
  end
endmodule : ssp_mac_model

// *** testbench/ssp_port_properties.sv ***
module ssp_port_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_n_a,
  input wire logic tx_idle_force,
  input wire logic [1:0] power_state,
  input wire logic elastic_buffer_mode_sel,
  input wire logic pclk,
  input wire logic rx_valid,
  input wire logic [2:0] rx_status,
  input wire logic completion_strobe,
  input wire logic tx_line_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  logic [3:0] mode_cnt;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !reset_n_a);
  // a status code may still stand from before the mode switched
  always_ff @(posedge aclk)
    if (!aresetn || !elastic_buffer_mode_sel)
      mode_cnt <= 4'h0;
    else if (mode_cnt != 4'hF)
      mode_cnt <= mode_cnt + 4'h1;
  no_underflow_a: assert property (mode_cnt >= 4'hC |-> rx_status != RXS_UNDERFLOW)
    else $error("underflow code in empty buffer mode");
  pclk_stop_a: assert property ((power_state == PS_P3)[*6] |-> !pclk)
    else $error("parallel clock runs in lowest power state");
  pclk_low_a: assert property ($rose(pclk) |-> !$past(pclk, 2) && !$past(pclk, 4))
    else $error("parallel clock low phase too short");
  idle_force_a: assert property (tx_idle_force[*4] |-> tx_line_idle)
    else $error("transmit idle not forced");
  idle_release_a: assert property ((!tx_idle_force && power_state == PS_P0)[*6]
    |-> !tx_line_idle)
    else $error("transmit idle without cause");
  done_width_a: assert property ($rose(completion_strobe) |-> completion_strobe[*8])
    else $error("completion pulse too short");
  done_delay_a: assert property ($changed(power_state) |-> ##[19:25] completion_strobe)
    else $error("no completion after power change");
  valid_beat_a: assert property ($rose(rx_valid) |-> $fell(pclk))
    else $error("receive valid off the clock beat");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : ssp_port_properties

bind ssp_port ssp_port_properties chk_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .reset_n_a, .tx_idle_force, .power_state,
  .elastic_buffer_mode_sel, .pclk, .rx_valid, .rx_status, .completion_strobe, .tx_line_idle);

// *** testbench/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d, w;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lv;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic reset_n_a, tx_clk, detect_or_loopback_req, tx_idle_force, compliance_toggle_pattern;
  logic elastic_buffer_mode_sel, config_mode_hi, config_mode_lo;
  logic [15:0] tx_data, rx_data, word_in;
  logic [1:0] tx_k_flags, power_state, deemphasis_select, rx_k_flags, k_in;
  logic [2:0] tx_voltage_margin, rx_status;
  logic pclk, rx_valid, rx_idle_indicator, completion_strobe, bus_power_present;
  logic tx_line_idle, tx_line_level;
  int fails, total_checks, cycles, n, i;
  ssp_port dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reset_n_a, .tx_clk, .tx_data, .tx_k_flags, .detect_or_loopback_req,
    .tx_idle_force, .power_state, .compliance_toggle_pattern, .deemphasis_select,
    .tx_voltage_margin, .elastic_buffer_mode_sel, .config_mode_hi, .config_mode_lo, .pclk,
    .rx_data, .rx_k_flags, .rx_valid, .rx_status, .rx_idle_indicator, .completion_strobe,
    .bus_power_present, .tx_line_idle, .tx_line_level);
  ssp_mac_model mac_u (.tx_clk, .tx_data, .tx_k_flags, .word_in, .k_in);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [2:0] exp_st(logic [2:0] c, logic m);
    return (m && c == RXS_UNDERFLOW) ? RXS_OK : c;
  endfunction : exp_st
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test();
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  task axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  // rready comes one cycle late on purpose so the slave must hold its answer
  task axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    seed = 32'h0000CDA3;
    {fails, total_checks, cycles} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, word_in, k_in, power_state} = '0;
    {detect_or_loopback_req, tx_idle_force, compliance_toggle_pattern} = '0;
    {elastic_buffer_mode_sel, config_mode_hi, tx_voltage_margin} = '0;
    s_axi_wstrb = 4'hF;
    reset_n_a = 1'b1;
    config_mode_lo = 1'b1;
    deemphasis_select = DEEMPH_RESET;
    tick(10);
    aresetn <= 1'b1;
    axi_read(ADDR_CTRL, d, r);
    chk(d, 32'h0);
    axi_read(ADDR_STATUS, d, r);
    chk(d & 32'h0000000F, {28'h0, DEEMPH_RESET, PS_P0});
    axi_read(4'h2, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_write(ADDR_CTRL, 32'h0000000D, r);
    chk(32'(r), 32'(RESP_OKAY));
    tick(4);
    chk(32'({rx_idle_indicator, bus_power_present}), 32'h1);
    axi_write(ADDR_CTRL, 32'h00000001, r);
    tick(4);
    chk(32'({rx_idle_indicator, bus_power_present}), 32'h2);
    for (i = 0; i < 16; i++)
    begin
      elastic_buffer_mode_sel <= i[3];
      d = rnd();
      w = {11'h0, i[2:0], d[17:0]};
      axi_write(ADDR_INJECT, w, r);
      while (rx_valid !== 1'b1) @(posedge aclk);
      d = 32'({exp_st(w[20:18], i[3]), w[17:0]});
      chk(32'({rx_status, rx_k_flags, rx_data}), d);
      while (rx_valid !== 1'b0) @(posedge aclk);
    end
    detect_or_loopback_req <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      d = rnd();
      word_in <= d[15:0];
      k_in <= d[17:16];
      tick(40);
      chk(32'({rx_valid, rx_k_flags, rx_data}), {13'h0, 1'b1, d[17:0]});
      axi_read(ADDR_TXCAP, w, r);
      chk(w, {14'h0, d[17:0]});
    end
    detect_or_loopback_req <= 1'b0;
    tick(20);
    for (i = 1; i < 5; i++)
    begin
      power_state <= i[1:0];
      while (completion_strobe !== 1'b1) @(posedge aclk);
      tick(40);
      chk(32'(tx_line_idle), 32'(i[1:0] != 2'h0));
      axi_read(ADDR_STATUS, d, r);
      chk(32'(d[1:0]), 32'(i[1:0]));
    end
    axi_write(ADDR_CTRL, 32'h00000003, r);
    power_state <= PS_P2;
    tick(45);
    detect_or_loopback_req <= 1'b1;
    while (completion_strobe !== 1'b1) @(posedge aclk);
    // the detected code follows the completion edge by one cycle
    tick(1);
    chk(32'(rx_status), 32'(RXS_DETECTED));
    detect_or_loopback_req <= 1'b0;
    tick(20);
    power_state <= PS_P0;
    tick(40);
    for (i = 0; i < 4; i++)
    begin
      d = rnd();
      deemphasis_select <= i[1:0];
      tx_voltage_margin <= (i == 0) ? MARGIN_NORMAL : d[2:0];
      // the read samples status about 130 ns after the pin change
      tick(10);
      axi_read(ADDR_STATUS, w, r);
      chk(32'(w[6:2]), 32'({tx_voltage_margin, i[1:0]}));
    end
    compliance_toggle_pattern <= 1'b1;
    tick(4);
    lv = tx_line_level;
    while (tx_line_level === lv) @(posedge aclk);
    lv = tx_line_level;
    n = 0;
    while (tx_line_level === lv)
    begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n), 32'(RUN_LEN));
    chk(32'(n >= 50 && n <= 250), 32'h1);
    compliance_toggle_pattern <= 1'b0;
    tx_idle_force <= 1'b1;
    tick(5);
    chk(32'(tx_line_idle), 32'h1);
    tx_idle_force <= 1'b0;
    tick(6);
    chk(32'(tx_line_idle), 32'h0);
    config_mode_hi <= 1'b1;
    axi_write(ADDR_INJECT, rnd() & 32'h0003FFFF, r);
    n = 0;
    repeat (24)
    begin
      @(posedge aclk);
      n = n + int'(rx_valid !== 1'b0);
    end
    chk(32'(n), 32'h0);
    config_mode_hi <= 1'b0;
    reset_n_a <= 1'b0;
    tick(6);
    chk(32'({pclk, rx_valid, tx_line_idle, completion_strobe, rx_idle_indicator}), 32'h5);
    reset_n_a <= 1'b1;
    tick(20);
    end_of_test();
  end
endmodule : tb
